/* File: hw/rcd_params.svh */
`ifndef RCD_PARAMS_SVH
`define RCD_PARAMS_SVH

// Timing and gain steps
`define RCD_CLK_MHZ 100
`define RCD_GAIN_WIN_MS 100
`define RCD_GAIN_WIN_CYC (`RCD_GAIN_WIN_MS * 1000 * `RCD_CLK_MHZ)
`define RCD_TICK_US 1
`define RCD_TICK_CYC (`RCD_TICK_US * `RCD_CLK_MHZ)
`define RCD_GAIN_STEP_DB 5
`define RCD_GAIN_MAX_DB 15
`define RCD_GAIN_MAX_STEP 2'((`RCD_GAIN_MAX_DB) / (`RCD_GAIN_STEP_DB))

// Register indices (byte address is four times the index)
`define RCD_IDX_CHIP 5'h00
`define RCD_IDX_ISO 5'h01
`define RCD_IDX_OPT_FIRST 5'h02
`define RCD_IDX_TXT_H 5'h04
`define RCD_IDX_TXT_L 5'h05
`define RCD_IDX_RXNR 5'h07
`define RCD_IDX_RXWAIT 5'h08
`define RCD_IDX_MODCLK 5'h09
`define RCD_IDX_RXSPEC 5'h0a
`define RCD_IDX_OPT_LAST 5'h0b
`define RCD_IDX_IRQ 5'h0c
`define RCD_IDX_COLL 5'h0e
`define RCD_IDX_RSSI 5'h0f
`define RCD_IDX_TEST 5'h1a
`define RCD_IDX_FIFO_ST 5'h1c
`define RCD_IDX_TXLEN1 5'h1d
`define RCD_IDX_TXLEN2 5'h1e
`define RCD_IDX_FIFO_IO 5'h1f
`define RCD_IDX_HOSTWORD 6'h20
`define RCD_IDX_HOSTDATA 6'h21

// Field positions
`define RCD_WORD_CMD 7
`define RCD_WORD_RD 6
`define RCD_WORD_CONT 5
`define RCD_CHIP_DIRECT 6
`define RCD_CHIP_RFON 5
`define RCD_CLO_LO 4
`define RCD_CLO_HI 5
`define RCD_MOD_CLO_MASK 8'h30

// Reset and preset values, and FIFO depth
`define RCD_CHIP_RST 8'h01
`define RCD_ISO_RST 8'h02
`define RCD_ISO_14443A 8'h08
`define RCD_RXNR_14443A 8'h0e
`define RCD_RXWAIT_14443A 8'h07
`define RCD_RXSPEC_14443A 8'h20
`define RCD_FIFO_DEPTH 4'hc

`endif

/* File: hw/rcd_pkg.sv */
package rcd_pkg;

  typedef enum logic [4:0] {
    rcd_cmd_idle = 5'h00,
    rcd_cmd_init = 5'h03,
    rcd_cmd_reset = 5'h0f,
    rcd_cmd_tx = 5'h10,
    rcd_cmd_tx_crc = 5'h11,
    rcd_cmd_dtx = 5'h12,
    rcd_cmd_dtx_crc = 5'h13,
    rcd_cmd_slot = 5'h14,
    rcd_cmd_rx_block = 5'h16,
    rcd_cmd_rx_enable = 5'h17,
    rcd_cmd_rf_int = 5'h18,
    rcd_cmd_rf_ext = 5'h19,
    rcd_cmd_gain = 5'h1a
  } rcd_cmd_t;

  typedef enum logic [2:0] {rcd_tx_idle, rcd_tx_data, rcd_tx_timer, rcd_tx_run, rcd_tx_rxhold} rcd_tx_st_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rcd_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } rcd_apb_rsp_t;

  typedef struct packed {
    logic [15:0][7:0] cfg;
    logic [7:0] txlen1;
    logic [7:0] txlen2;
    logic [3:0] fifo_cnt;
    logic [4:0] ptr;
    logic ptr_rd;
    logic ptr_cont;
    rcd_tx_st_t tx_st;
    logic tx_crc;
    logic tx_start;
    logic tx_busy;
    logic [15:0] tmr;
    logic [7:0] rx_wait;
    logic [6:0] tick_cnt;
    logic rx_block;
    logic slot;
    logic gain_run;
    logic gain_go;
    logic [1:0] gain_step;
    logic ss_s1;
    logic ss_s2;
    logic ss_d;
    logic rxd_s1;
    logic rxd_s2;
    logic [5:0] lvl_s1;
    logic [5:0] lvl_s2;
    rcd_apb_rsp_t rsp;
  } rcd_state_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic [23:0] cnt;
    logic [1:0] edges;
    logic prev;
  } rcd_win_t;

endpackage : rcd_pkg

/* File: hw/rcd_edge_window.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rcd_params.svh"

// Counts level changes of a sampled signal over one window, saturating at three
module rcd_edge_window import rcd_pkg::*; #(
  parameter int unsigned WIN_CYC = `RCD_GAIN_WIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // Control
  input wire logic start_i,
  input wire logic sample_i,
  // Result
  output logic busy_o,
  output logic done_o,
  output logic [1:0] edges_o
);

  rcd_win_t w_r;
  rcd_win_t w_nxt;

  always_comb begin
    w_nxt = w_r;
    w_nxt.done = 1'b0;
    w_nxt.prev = sample_i;
    if (w_r.busy) begin
      if (sample_i != w_r.prev && w_r.edges != 2'h3) begin
        w_nxt.edges = w_r.edges + 2'h1;
      end
      if (w_r.cnt == 24'h0) begin
        w_nxt.busy = 1'b0;
        w_nxt.done = 1'b1;
      end else begin
        w_nxt.cnt = w_r.cnt - 24'h1;
      end
    end else if (start_i) begin
      w_nxt.busy = 1'b1;
      w_nxt.edges = 2'h0;
      w_nxt.cnt = 24'(WIN_CYC - 1);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      w_r <= '0;
    end else begin
      w_r <= w_nxt;
    end
  end

  assign busy_o = w_r.busy;
  assign done_o = w_r.done;
  assign edges_o = w_r.edges;

  win_len_a: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (start_i && !w_r.busy) |=> w_r.busy && w_r.cnt == 24'(WIN_CYC - 1))
    else $error("edge window did not load its length");

endmodule : rcd_edge_window
`default_nettype wire

/* File: hw/rcd_decoder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "rcd_params.svh"

module rcd_decoder import rcd_pkg::*; #(
  parameter int unsigned GAIN_WIN_CYC = `RCD_GAIN_WIN_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // APB slave
  input wire rcd_apb_req_t apb_i,
  output rcd_apb_rsp_t apb_o,
  // Pins from the analog side and the host
  input wire logic host_ss_n_i,
  input wire logic rx_digital_i,
  input wire logic [2:0] rx_input_main_lvl_i,
  input wire logic [2:0] rx_input_aux_lvl_i,
  // Framer status
  input wire logic tx_done_i,
  // Framer and front-end control
  output logic tx_start_o,
  output logic tx_crc_o,
  output logic tx_busy_o,
  output logic slot_mark_o,
  output logic [7:0] slot_form_o,
  output logic rx_block_o,
  output logic direct_mode_o,
  output logic [1:0] gain_cut_o,
  output logic clkout_div_sel_lo_o,
  output logic clkout_div_sel_hi_o
);

  rcd_state_t st_r;
  rcd_state_t st_nxt;
  logic win_busy;
  logic win_done;
  logic [1:0] win_edges;
  logic [5:0] idx;
  logic [7:0] wd;
  logic access;
  logic fire;
  logic cmd_go;
  logic direct;
  logic tick;
  logic win_rst;

  function automatic logic [7:0] rd_reg(input rcd_state_t s, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a <= `RCD_IDX_RSSI) begin
      v = s.cfg[a[3:0]];
    end else if (a == `RCD_IDX_FIFO_ST) begin
      v = {4'h0, s.fifo_cnt};
    end else if (a == `RCD_IDX_TXLEN1) begin
      v = s.txlen1;
    end else if (a == `RCD_IDX_TXLEN2) begin
      v = s.txlen2;
    end
    return v;
  endfunction : rd_reg

  function automatic logic mapped(input logic [5:0] i);
    logic m;
    if (i[5]) begin
      m = (i <= `RCD_IDX_HOSTDATA);
    end else begin
      m = (i[4:0] <= `RCD_IDX_RSSI) || (i[4:0] >= `RCD_IDX_TEST);
    end
    return m;
  endfunction : mapped

  // Only the 14443A set differs from all-zero; other protocols preset to zero
  function automatic logic [7:0] opt_default(input logic [7:0] proto, input logic [4:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (proto == `RCD_ISO_14443A) begin
      case (a)
        `RCD_IDX_RXNR: v = `RCD_RXNR_14443A;
        `RCD_IDX_RXWAIT: v = `RCD_RXWAIT_14443A;
        `RCD_IDX_RXSPEC: v = `RCD_RXSPEC_14443A;
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction : opt_default

  function automatic rcd_state_t rst_state();
    rcd_state_t s;
    s = '0;
    s.cfg[`RCD_IDX_CHIP] = `RCD_CHIP_RST;
    s.cfg[`RCD_IDX_ISO] = `RCD_ISO_RST;
    s.ss_s1 = 1'b1;
    s.ss_s2 = 1'b1;
    s.ss_d = 1'b1;
    return s;
  endfunction : rst_state

  assign access = apb_i.psel && apb_i.penable;
  assign fire = access && st_r.rsp.pready;
  assign idx = apb_i.paddr[7:2];
  assign wd = apb_i.pwdata[7:0];
  assign direct = st_r.cfg[`RCD_IDX_CHIP][`RCD_CHIP_DIRECT];
  assign cmd_go = fire && apb_i.pwrite && !direct && apb_i.paddr[1:0] == 2'h0 && idx == `RCD_IDX_HOSTWORD &&
    wd[`RCD_WORD_CMD] && !wd[`RCD_WORD_RD];
  assign tick = (st_r.tick_cnt == 7'(`RCD_TICK_CYC - 1));
  // Software init must also abort a running window, or its stale count would leak into the next adjust
  assign win_rst = reset_i || (cmd_go && wd[4:0] == rcd_cmd_init);

  rcd_edge_window #(
    .WIN_CYC(GAIN_WIN_CYC)
  ) u_win (
    .sys_clk_i(sys_clk_i),
    .reset_i(win_rst),
    .start_i(st_r.gain_go),
    .sample_i(st_r.rxd_s2),
    .busy_o(win_busy),
    .done_o(win_done),
    .edges_o(win_edges)
  );

  always_comb begin
    logic bad;
    logic we;
    logic [4:0] wa;
    logic [7:0] rv;
    bad = 1'b0;
    we = 1'b0;
    wa = 5'h00;
    rv = 8'h00;
    st_nxt = st_r;
    st_nxt.tx_start = 1'b0;
    st_nxt.slot = 1'b0;
    st_nxt.gain_go = 1'b0;
    st_nxt.ss_s1 = host_ss_n_i;
    st_nxt.ss_s2 = st_r.ss_s1;
    st_nxt.ss_d = st_r.ss_s2;
    st_nxt.rxd_s1 = rx_digital_i;
    st_nxt.rxd_s2 = st_r.rxd_s1;
    st_nxt.lvl_s1 = {rx_input_aux_lvl_i, rx_input_main_lvl_i};
    st_nxt.lvl_s2 = st_r.lvl_s1;
    st_nxt.tick_cnt = tick ? 7'h00 : st_r.tick_cnt + 7'h01;

    // Two-cycle access: the answer is prepared while pready is low
    st_nxt.rsp.pready = access && !st_r.rsp.pready;
    if (access && !st_r.rsp.pready) begin
      bad = !mapped(idx) || apb_i.paddr[1:0] != 2'h0 || (direct && apb_i.pwrite);
      if (idx == `RCD_IDX_HOSTDATA) begin
        rv = rd_reg(st_r, st_r.ptr);
        bad = bad || (apb_i.pwrite == st_r.ptr_rd);
      end else if (!idx[5]) begin
        rv = rd_reg(st_r, idx[4:0]);
      end
      st_nxt.rsp.pslverr = bad;
      st_nxt.rsp.prdata = bad ? 32'h0 : {24'h0, rv};
    end

    if (fire && !st_r.rsp.pslverr) begin
      if (idx == `RCD_IDX_HOSTWORD && apb_i.pwrite && !wd[`RCD_WORD_CMD]) begin
        st_nxt.ptr = wd[4:0];
        st_nxt.ptr_rd = wd[`RCD_WORD_RD];
        st_nxt.ptr_cont = wd[`RCD_WORD_CONT];
      end else if (idx == `RCD_IDX_HOSTDATA) begin
        we = !st_r.ptr_rd;
        wa = st_r.ptr;
        if (st_r.ptr_cont) begin
          st_nxt.ptr = st_r.ptr + 5'h01;
        end
      end else if (!idx[5] && apb_i.pwrite) begin
        we = 1'b1;
        wa = idx[4:0];
      end
    end

    // Register writes; status registers are read-only from the bus
    if (we && !direct) begin
      if (wa <= `RCD_IDX_OPT_LAST || wa == 5'h0d) begin
        st_nxt.cfg[wa[3:0]] = wd;
      end
      if (wa == `RCD_IDX_ISO) begin
        for (int i = `RCD_IDX_OPT_FIRST; i <= `RCD_IDX_OPT_LAST; i++) begin
          st_nxt.cfg[i] = opt_default(wd, 5'(i));
        end
        st_nxt.cfg[`RCD_IDX_MODCLK] = (opt_default(wd, `RCD_IDX_MODCLK) & ~`RCD_MOD_CLO_MASK) |
          (st_r.cfg[`RCD_IDX_MODCLK] & `RCD_MOD_CLO_MASK);
      end
      if (wa == `RCD_IDX_TXLEN1) begin
        st_nxt.txlen1 = wd;
      end
      if (wa == `RCD_IDX_TXLEN2) begin
        st_nxt.txlen2 = wd;
      end
      if (wa == `RCD_IDX_FIFO_IO && st_r.fifo_cnt != `RCD_FIFO_DEPTH) begin
        st_nxt.fifo_cnt = st_r.fifo_cnt + 4'h1;
      end
    end

    // Transmit sequencing and receiver hold after transmit
    case (st_r.tx_st)
      rcd_tx_data: begin
        if (st_r.fifo_cnt != 4'h0) begin
          st_nxt.tx_start = 1'b1;
          st_nxt.tx_st = rcd_tx_run;
        end
      end
      rcd_tx_timer: begin
        if (tick) begin
          if (st_r.tmr == 16'h0) begin
            st_nxt.tx_st = rcd_tx_data;
          end else begin
            st_nxt.tmr = st_r.tmr - 16'h1;
          end
        end
      end
      rcd_tx_run: begin
        if (tx_done_i) begin
          st_nxt.fifo_cnt = 4'h0;
          if (st_r.cfg[`RCD_IDX_RXWAIT] != 8'h00) begin
            st_nxt.rx_block = 1'b1;
            st_nxt.rx_wait = st_r.cfg[`RCD_IDX_RXWAIT];
            st_nxt.tx_st = rcd_tx_rxhold;
          end else begin
            st_nxt.rx_block = 1'b0;
            st_nxt.tx_st = rcd_tx_idle;
          end
        end
      end
      rcd_tx_rxhold: begin
        if (tick) begin
          if (st_r.rx_wait <= 8'h01) begin
            st_nxt.rx_block = 1'b0;
            st_nxt.tx_st = rcd_tx_idle;
          end else begin
            st_nxt.rx_wait = st_r.rx_wait - 8'h01;
          end
        end
      end
      default: begin
      end
    endcase

    // Gain reduction loop: one window per step until quiet or at the limit
    if (st_r.gain_run && win_done) begin
      if (win_edges > 2'h2 && st_r.gain_step != `RCD_GAIN_MAX_STEP) begin
        st_nxt.gain_step = st_r.gain_step + 2'h1;
        st_nxt.gain_go = 1'b1;
      end else begin
        st_nxt.gain_run = 1'b0;
      end
    end

    if (cmd_go) begin
      case (wd[4:0])
        rcd_cmd_reset: begin
          st_nxt.fifo_cnt = 4'h0;
          st_nxt.cfg[`RCD_IDX_COLL] = 8'h00;
        end
        rcd_cmd_tx, rcd_cmd_tx_crc, rcd_cmd_dtx, rcd_cmd_dtx_crc: begin
          st_nxt.tx_crc = wd[0];
          st_nxt.tmr = {st_r.cfg[`RCD_IDX_TXT_H], st_r.cfg[`RCD_IDX_TXT_L]};
          st_nxt.tx_st = wd[1] ? rcd_tx_timer : rcd_tx_data;
        end
        rcd_cmd_slot: st_nxt.slot = 1'b1;
        rcd_cmd_rx_block: st_nxt.rx_block = 1'b1;
        rcd_cmd_rx_enable: st_nxt.rx_block = 1'b0;
        rcd_cmd_rf_int: st_nxt.cfg[`RCD_IDX_RSSI] = {2'h0, st_r.lvl_s2};
        rcd_cmd_rf_ext: begin
          if (!st_r.cfg[`RCD_IDX_CHIP][`RCD_CHIP_RFON]) begin
            st_nxt.cfg[`RCD_IDX_RSSI] = {5'h00, st_r.lvl_s2[2:0]};
          end
        end
        rcd_cmd_gain: begin
          if (!st_r.gain_run) begin
            st_nxt.gain_run = 1'b1;
            st_nxt.gain_go = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end

    // Stop condition leaves direct mode
    if (st_r.ss_s2 && !st_r.ss_d) begin
      st_nxt.cfg[`RCD_IDX_CHIP][`RCD_CHIP_DIRECT] = 1'b0;
    end

    // Software init matches power-on, but lets the current bus answer finish
    if (cmd_go && wd[4:0] == rcd_cmd_init) begin
      st_nxt = rst_state();
      st_nxt.rsp = st_r.rsp;
      st_nxt.rsp.pready = 1'b0;
    end
    st_nxt.tx_busy = (st_nxt.tx_st == rcd_tx_run);
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= rst_state();
    end else begin
      st_r <= st_nxt;
    end
  end

  assign apb_o = st_r.rsp;
  assign tx_start_o = st_r.tx_start;
  assign tx_crc_o = st_r.tx_crc;
  assign tx_busy_o = st_r.tx_busy;
  assign slot_mark_o = st_r.slot;
  assign slot_form_o = st_r.cfg[`RCD_IDX_ISO];
  assign rx_block_o = st_r.rx_block;
  assign direct_mode_o = direct;
  assign gain_cut_o = st_r.gain_step;
  assign clkout_div_sel_lo_o = st_r.cfg[`RCD_IDX_MODCLK][`RCD_CLO_LO];
  assign clkout_div_sel_hi_o = st_r.cfg[`RCD_IDX_MODCLK][`RCD_CLO_HI];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);

  sequence s_imm_cmd;
    cmd_go && wd[4:1] == 4'h8 && st_r.fifo_cnt != 4'h0;
  endsequence
  sequence s_slot_pulse;
    slot_mark_o ##1 !slot_mark_o;
  endsequence

  fifo_reset_a: assert property (cmd_go && wd[4:0] == 5'h0f |=> st_r.fifo_cnt == 4'h0 && st_r.cfg[14] == 8'h00)
    else $error("reset command left FIFO or collision state");
  tx_imm_a: assert property (s_imm_cmd |=> ##1 tx_start_o)
    else $error("immediate transmit did not start");
  tx_crc_a: assert property (cmd_go && wd[4:0] == 5'h13 |=> tx_crc_o until_with tx_start_o)
    else $error("CRC flag lost for CRC transmit");
  tx_delay_a: assert property (st_r.tx_st == rcd_tx_timer |=> !tx_start_o)
    else $error("delayed transmit started before timer expiry");
  slot_pulse_a: assert property (cmd_go && wd[4:0] == 5'h14 |=> s_slot_pulse)
    else $error("slot marker not a single pulse");
  rx_block_a: assert property (cmd_go && wd[4:0] == 5'h16 |=> rx_block_o)
    else $error("receiver not held after block command");
  rx_release_a: assert property (st_r.tx_st == rcd_tx_run && tx_done_i && st_r.cfg[8] == 8'h00 |=> !rx_block_o)
    else $error("receiver not released after transmit");
  rx_wait_a: assert property (st_r.tx_st == rcd_tx_run && tx_done_i && st_r.cfg[8] != 8'h00 |=> rx_block_o [*2])
    else $error("receiver released before wait time");
  rssi_int_a: assert property (cmd_go && wd[4:0] == 5'h18 |=> st_r.cfg[15] == {2'h0, $past(st_r.lvl_s2)})
    else $error("RSSI not captured");
  rssi_ext_a: assert property (cmd_go && wd[4:0] == 5'h19 && st_r.cfg[0][5] |=> $stable(st_r.cfg[15]))
    else $error("external check ran with RF output on");
  gain_quiet_a: assert property (st_r.gain_run && win_done && win_edges < 2'h2 |=> $stable(gain_cut_o) && !st_r.gain_run)
    else $error("gain changed on a quiet window");
  clo_keep_a: assert property (fire && !st_r.rsp.pslverr && apb_i.pwrite && !direct && idx == 6'h01 |=>
    (st_r.cfg[9] & 8'h30) == ($past(st_r.cfg[9]) & 8'h30) && st_r.cfg[7] == opt_default($past(wd), 5'h07))
    else $error("protocol preset wrong");
  stop_exit_a: assert property (st_r.ss_s2 && !st_r.ss_d && !cmd_go |=> !direct_mode_o)
    else $error("stop condition did not leave direct mode");
  undef_cmd_a: assert property (cmd_go && wd[4:0] == 5'h05 |=> $stable(st_r.cfg) && $stable(st_r.fifo_cnt))
    else $error("undefined command changed state");

endmodule : rcd_decoder
`default_nettype wire

/* File: dv/rcd_framer_model.sv */
`timescale 1ns/10ps
`default_nettype none

// Far-side framer: ends each transmit a fixed time after it starts, and can chatter the receive line
module rcd_framer_model #(
  parameter int DONE_DLY = 20
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_i,
  // From the decoder and the testbench
  input wire logic tx_start_i,
  input wire logic noisy_i,
  // To the decoder
  output logic tx_done_o,
  output logic rx_digital_o
);
  logic [7:0] cnt_r;
  logic run_r;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      run_r <= 1'b0;
      cnt_r <= 8'h00;
      tx_done_o <= 1'b0;
      rx_digital_o <= 1'b0;
    end else begin
      tx_done_o <= 1'b0;
      if (tx_start_i) begin
        run_r <= 1'b1;
        cnt_r <= 8'(DONE_DLY);
      end else if (run_r) begin
        cnt_r <= cnt_r - 8'h01;
        if (cnt_r == 8'h01) begin
          run_r <= 1'b0;
          tx_done_o <= 1'b1;
        end
      end
      // Noise toggles every cycle so each gain window sees far more than two edges
      if (noisy_i) begin
        rx_digital_o <= ~rx_digital_o;
      end
    end
  end
endmodule : rcd_framer_model
`default_nettype wire

/* File: dv/testbench.sv */
`timescale 1ns/10ps
`default_nettype none

module testbench import rcd_pkg::*; ();
  logic clk = 1'b0;
  logic rst = 1'b1;
  rcd_apb_req_t req = '0;
  rcd_apb_rsp_t rsp;
  logic ss_n = 1'b0;
  logic noisy = 1'b0;
  logic [2:0] lvl_main = 3'h0;
  logic [2:0] lvl_aux = 3'h0;
  logic tx_done, rx_dig, tx_start, tx_crc, tx_busy, slot_mark, rx_block, direct, clo_lo, clo_hi;
  logic [7:0] slot_form;
  logic [1:0] gain_cut;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_start = 0;
  int n_slot = 0;
  int t_start = 0;
  logic crc_at = 1'b0;

  always #5 clk = ~clk;

  rcd_decoder #(.GAIN_WIN_CYC(50)) u_dut (.sys_clk_i(clk), .reset_i(rst), .apb_i(req), .apb_o(rsp),
    .host_ss_n_i(ss_n), .rx_digital_i(rx_dig), .rx_input_main_lvl_i(lvl_main), .rx_input_aux_lvl_i(lvl_aux),
    .tx_done_i(tx_done), .tx_start_o(tx_start), .tx_crc_o(tx_crc), .tx_busy_o(tx_busy),
    .slot_mark_o(slot_mark), .slot_form_o(slot_form), .rx_block_o(rx_block), .direct_mode_o(direct),
    .gain_cut_o(gain_cut), .clkout_div_sel_lo_o(clo_lo), .clkout_div_sel_hi_o(clo_hi));

  rcd_framer_model #(.DONE_DLY(20)) u_fr (.sys_clk_i(clk), .reset_i(rst), .tx_start_i(tx_start),
    .noisy_i(noisy), .tx_done_o(tx_done), .rx_digital_o(rx_dig));

  // Pulses are counted here so no scenario can miss a one-cycle output
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tx_start === 1'b1) begin
      n_start <= n_start + 1;
      t_start <= cyc;
      crc_at <= tx_crc;
    end
    if (slot_mark === 1'b1) begin
      n_slot <= n_slot + 1;
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : check

  // Ready and data are taken at the rising edge that completes the access;
  // returning half a cycle later lets callers look at settled effects
  task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: {24'h0, d}};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 20);
    check(32'(n < 20), 32'h1, "pready timeout");
    q = rsp.prdata[7:0];
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
    @(negedge clk);
  endtask : apb

  task automatic wr_err(input logic [7:0] a, input logic [7:0] d, input logic exp_err);
    logic [7:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
    check(32'(e), 32'(exp_err), "write response");
  endtask : wr_err

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wr_err(a, d, 1'b0);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic exp_err);
    logic [7:0] q;
    logic e;
    apb(1'b0, a, 8'h00, q, e);
    check({e, q}, {exp_err, exp}, "read");
  endtask : rd

  task automatic cmd(input logic [4:0] code);
    wr(8'h80, {3'b100, code});
    repeat (2) @(negedge clk);
  endtask : cmd

  // Start must wait for the first FIFO byte, then land within the allowed span
  task automatic tx_run(input logic [4:0] code, input int minc, input int maxc);
    int p;
    int c0;
    int k;
    p = n_start;
    cmd(code);
    repeat (20) @(posedge clk);
    check(n_start, p, "start before data");
    wr(8'h7c, 8'h5a);
    c0 = cyc;
    k = 0;
    while (n_start == p && k < maxc) begin
      @(posedge clk);
      k++;
    end
    @(negedge clk);
    check(n_start, p + 1, "no start");
    check(32'(t_start - c0 >= minc), 32'h1, "start too early");
    check(32'(crc_at), 32'(code[0]), "crc select");
    check(tx_busy, 1'b1, "busy while sending");
    repeat (30) @(posedge clk);
    check(tx_busy, 1'b0, "busy after done");
  endtask : tx_run

  task automatic t_reset();
    rd(8'h00, 8'h01, 1'b0);
    rd(8'h04, 8'h02, 1'b0);
    check(slot_form, 8'h02, "protocol default");
    check(gain_cut, 2'h0, "gain default");
    rd(8'h40, 8'h00, 1'b1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_word();
    logic [4:0] codes [3] = '{5'h00, 5'h05, 5'h1f};
    wr(8'h80, 8'h60);
    rd(8'h84, 8'h01, 1'b0);
    rd(8'h84, 8'h02, 1'b0);
    wr(8'h80, 8'hd6);
    check(rx_block, 1'b0, "read-flagged command acted");
    foreach (codes[i]) begin
      cmd(codes[i]);
      check(rx_block, 1'b0, "no-op touched receiver");
      rd(8'h04, 8'h02, 1'b0);
    end
    $display("test word done");
  endtask : t_word

  task automatic t_rx();
    cmd(5'h16);
    check(rx_block, 1'b1, "block");
    cmd(5'h05);
    check(rx_block, 1'b1, "no-op released");
    cmd(5'h17);
    check(rx_block, 1'b0, "enable");
    $display("test receiver done");
  endtask : t_rx

  task automatic t_tx();
    wr(8'h74, 8'h00);
    wr(8'h78, 8'h10);
    cmd(5'h16);
    tx_run(5'h11, 0, 10);
    check(rx_block, 1'b0, "not released by tx end");
    wr(8'h20, 8'h03);
    cmd(5'h16);
    tx_run(5'h10, 0, 10);
    repeat (60) @(posedge clk);
    check(rx_block, 1'b1, "released before wait");
    repeat (300) @(posedge clk);
    check(rx_block, 1'b0, "not released after wait");
    wr(8'h10, 8'h00);
    wr(8'h14, 8'h03);
    tx_run(5'h13, 250, 600);
    tx_run(5'h12, 250, 600);
    $display("test transmit done");
  endtask : t_tx

  task automatic t_misc();
    int p;
    p = n_slot;
    cmd(5'h14);
    repeat (3) @(posedge clk);
    check(n_slot, p + 1, "slot pulse");
    cmd(5'h17);
    cmd(5'h18);
    rd(8'h3c, 8'h2b, 1'b0);
    cmd(5'h19);
    rd(8'h3c, 8'h03, 1'b0);
    p = n_start;
    wr(8'h7c, 8'h01);
    cmd(5'h10);
    repeat (10) @(posedge clk);
    check(n_start, p + 1, "queued data not sent");
    repeat (30) @(posedge clk);
    wr(8'h7c, 8'h01);
    wr(8'h7c, 8'h02);
    rd(8'h70, 8'h02, 1'b0);
    cmd(5'h0f);
    rd(8'h70, 8'h00, 1'b0);
    rd(8'h38, 8'h00, 1'b0);
    $display("test misc done");
  endtask : t_misc

  task automatic t_proto();
    wr(8'h24, 8'h3f);
    wr(8'h1c, 8'h55);
    wr(8'h04, 8'h08);
    rd(8'h1c, 8'h0e, 1'b0);
    rd(8'h20, 8'h07, 1'b0);
    rd(8'h28, 8'h20, 1'b0);
    rd(8'h24, 8'h30, 1'b0);
    check({clo_hi, clo_lo, slot_form}, {2'b11, 8'h08}, "divider kept");
    wr(8'h04, 8'h02);
    rd(8'h1c, 8'h00, 1'b0);
    $display("test protocol done");
  endtask : t_proto

  task automatic t_direct();
    wr(8'h00, 8'h41);
    check(direct, 1'b1, "direct entry");
    wr_err(8'h10, 8'h55, 1'b1);
    @(posedge clk);
    ss_n <= 1'b1;
    repeat (8) @(posedge clk);
    check(direct, 1'b0, "stop kept direct");
    rd(8'h00, 8'h01, 1'b0);
    @(posedge clk);
    ss_n <= 1'b0;
    $display("test direct done");
  endtask : t_direct

  task automatic t_gain();
    int k;
    wr(8'h00, 8'h21);
    @(posedge clk);
    noisy <= 1'b1;
    lvl_main <= 3'h6;
    cmd(5'h19);
    rd(8'h3c, 8'h03, 1'b0);
    cmd(5'h1a);
    k = 0;
    while (gain_cut !== 2'h3 && k < 1000) begin
      @(negedge clk);
      k++;
    end
    check(gain_cut, 2'h3, "gain steps");
    @(posedge clk);
    noisy <= 1'b0;
    cmd(5'h03);
    check(gain_cut, 2'h0, "gain after init");
    rd(8'h00, 8'h01, 1'b0);
    cmd(5'h1a);
    repeat (300) @(posedge clk);
    check(gain_cut, 2'h0, "quiet line cut gain");
    $display("test gain done");
  endtask : t_gain

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : finish_test

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    lvl_main <= 3'h3;
    lvl_aux <= 3'h5;
    t_reset();
    t_word();
    t_rx();
    t_tx();
    t_misc();
    t_proto();
    t_direct();
    t_gain();
    finish_test();
  end

  // The whole sequence needs a few thousand cycles
  initial begin
    repeat (30000) @(posedge clk);
    errors++;
    finish_test();
  end
endmodule : testbench
`default_nettype wire
